// ==== dps_top.sv ====
`timescale 1ns/1ps
module dps_top
  import dps_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // Parameter access port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // Operator panel requests (asynchronous pins)
  input  wire logic        panel_factory_code,
  input  wire logic        panel_tuning_reset_code,
  // Nonvolatile memory write channel
  output logic             nv_req,
  output logic      [1:0]  nv_addr,
  output logic      [31:0] nv_wdata,
  input  wire logic        nv_ack,
  // Effects on the control loops
  output logic             loop_gains_default,
  output logic             current_loop_autoset,
  output logic             rotation_ccw,
  output logic      [31:0] scale_multiplier_active,
  output logic      [31:0] scale_divisor_active
);

  // ----------------------------------------------------------------
  // Stored and active state
  // ----------------------------------------------------------------
  logic        rot_stored_r;
  logic [31:0] div_stored_r;
  logic [31:0] mul_stored_r;
  logic        rot_active_r;
  logic [31:0] div_active_r;
  logic [31:0] mul_active_r;
  logic        started_r;
  logic        gains_pulse_r;
  logic        autoset_pulse_r;
  logic        store_pending_r;
  logic        factory_busy_r;
  logic [31:0] rdata_r;
  logic        ack_r;
  logic        err_r;
  logic [1:0]  panel_lvl;
  logic [1:0]  panel_prev_r;

  // ----------------------------------------------------------------
  // Panel inputs
  // ----------------------------------------------------------------
  // Pins are asynchronous, so filter them first
  dps_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_in    ({panel_tuning_reset_code, panel_factory_code}),
    .level_out (panel_lvl)
  );

  // Panel edge memory for rising-edge detection on the filtered levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      panel_prev_r <= 2'b00;
    end else begin
      panel_prev_r <= panel_lvl;
    end
  end

  // Edges of the filtered levels; pins idle low
  logic panel_factory_rise;
  logic panel_tuning_rise;
  assign panel_factory_rise = panel_lvl[0] & ~panel_prev_r[0];
  assign panel_tuning_rise  = panel_lvl[1] & ~panel_prev_r[1];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One select per mapped parameter word
  logic hit_tuning;
  logic hit_store;
  logic hit_user;
  logic hit_factory;
  logic hit_div;
  logic hit_mul;
  logic hit_rot;
  logic hit_any;

  // Full compare, so no word has an alias
  assign hit_tuning  = (par_addr == ADDR_TUNING_RESET);
  assign hit_store   = (par_addr == ADDR_NV_STORE);
  assign hit_user    = (par_addr == ADDR_USER_DEFAULT);
  assign hit_factory = (par_addr == ADDR_FACTORY);
  assign hit_div     = (par_addr == ADDR_SCALE_DIV);
  assign hit_mul     = (par_addr == ADDR_SCALE_MUL);
  assign hit_rot     = (par_addr == ADDR_ROTATION);
  assign hit_any     = hit_tuning | hit_store | hit_user | hit_factory
                     | hit_div | hit_mul | hit_rot;

  // ----------------------------------------------------------------
  // Range checks
  // ----------------------------------------------------------------
  // Write data checks and the save guard
  logic nv_busy;
  logic busy_any;
  logic scale_ok;
  logic rot_ok;
  logic cmd_one;
  logic store_ok;
  logic factory_ok;

  // Save pending or running; blocks writes
  assign busy_any   = nv_busy | store_pending_r;
  assign scale_ok   = (par_wdata >= SCALE_MIN) && (par_wdata <= SCALE_MAX);
  assign rot_ok     = (par_wdata == 32'(ROT_CLOCKWISE))
                    | (par_wdata == 32'(ROT_COUNTERCLOCK));
  assign cmd_one    = (par_wdata == CMD_EXECUTE);
  assign store_ok   = par_wdata[STORE_USER_BIT] && (par_wdata[31:16] == 16'h0000);
  assign factory_ok = (par_wdata <= FACTORY_MAX);

  // ----------------------------------------------------------------
  // Accepted write strobes
  // ----------------------------------------------------------------
  // Qualified strobes, one per action
  logic wr_ok;
  logic do_tuning;
  logic do_store;
  logic do_user;
  logic do_factory;
  logic wr_div;
  logic wr_mul;
  logic wr_rot;
  logic wr_refused;

  // Writes during a store are refused so the saved image stays coherent
  assign wr_ok      = par_wr & ~busy_any;
  assign do_tuning  = (wr_ok & hit_tuning & cmd_one) | panel_tuning_rise;
  assign do_store   = wr_ok & hit_store & store_ok;
  assign do_user    = wr_ok & hit_user & cmd_one;
  // A factory panel press during a save is dropped; a tuning panel press is not
  // panel or port
  assign do_factory = (wr_ok & hit_factory & cmd_one)
                    | (panel_factory_rise & ~busy_any);
  assign wr_div     = wr_ok & hit_div & scale_ok;
  assign wr_mul     = wr_ok & hit_mul & scale_ok;
  assign wr_rot     = wr_ok & hit_rot & rot_ok;
  assign wr_refused = par_wr & (~hit_any | busy_any
                    | (hit_tuning & ~cmd_one & (par_wdata != 32'h0))
                    | (hit_store & ~store_ok & (par_wdata != 32'h0))
                    | (hit_user & ~cmd_one & (par_wdata != 32'h0))
                    | (hit_factory & ~factory_ok)
                    | ((hit_div | hit_mul) & ~scale_ok)
                    | (hit_rot & ~rot_ok));

  // ----------------------------------------------------------------
  // Stored parameter set
  // ----------------------------------------------------------------
  // Both default commands load defaults into the stored set; only the
  // factory command also saves them. None of these three words is a
  // communication, device control or logic type parameter.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rot_stored_r <= ROT_DEFAULT;
      div_stored_r <= SCALE_DIV_DEFAULT;
      mul_stored_r <= SCALE_MUL_DEFAULT;
    end else if (do_factory | do_user) begin
      rot_stored_r <= ROT_DEFAULT;
      div_stored_r <= SCALE_DIV_DEFAULT;
      mul_stored_r <= SCALE_MUL_DEFAULT;
    end else begin
      if (wr_rot) begin
        rot_stored_r <= par_wdata[0];
      end
      if (wr_div) begin
        div_stored_r <= par_wdata;
      end
      if (wr_mul) begin
        mul_stored_r <= par_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Active configuration
  // ----------------------------------------------------------------
  // Rotation sense is taken once, at the first edge after reset release;
  // reset stands for power-up here and reloads the stored sense with ROT_DEFAULT, so later writes never reach rotation_ccw.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      started_r    <= 1'b0;
      rot_active_r <= ROT_DEFAULT;
    end else if (!started_r) begin
      started_r <= 1'b1;
      rot_active_r <= rot_stored_r;
    end
  end

  // Scale pair moves together on a multiplier write, so a half-updated
  // ratio never reaches the position loop
  // factory not applied
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_active_r <= SCALE_DIV_DEFAULT;
      mul_active_r <= SCALE_MUL_DEFAULT;
    end else if (do_user) begin
      div_active_r <= SCALE_DIV_DEFAULT;
      mul_active_r <= SCALE_MUL_DEFAULT;
    end else if (wr_mul) begin
      div_active_r <= div_stored_r;
      mul_active_r <= par_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Controller tuning reset pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gains_pulse_r   <= 1'b0;
      autoset_pulse_r <= 1'b0;
    end else begin
      gains_pulse_r   <= do_tuning;
      autoset_pulse_r <= do_tuning;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile store sequencing
  // ----------------------------------------------------------------
  // The factory save starts one cycle late so the image holds defaults
  logic        nv_start;
  logic [1:0]  nv_idx;
  logic [31:0] nv_word;

  // Pending pulse and factory marker
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      store_pending_r <= 1'b0;
      factory_busy_r  <= 1'b0;
    end else begin
      store_pending_r <= do_store | do_factory;
      if (do_factory) begin
        factory_busy_r <= 1'b1;
      end else if (!nv_busy && !store_pending_r) begin
        factory_busy_r <= 1'b0;
      end
    end
  end

  assign nv_start = store_pending_r;

  // Image word for the engine's index
  assign nv_word = (nv_idx == NV_IDX_ROTATION) ? {31'h0, rot_stored_r} :
                   (nv_idx == NV_IDX_DIV)      ? div_stored_r :
                   (nv_idx == NV_IDX_MUL)      ? mul_stored_r : 32'h0000_0000;

  // Engine walks the image words in order
  dps_nv_engine u_nv (
    .clock     (clock),
    .rst       (rst),
    .start     (nv_start),
    .word_data (nv_word),
    .nv_ack    (nv_ack),
    .word_idx  (nv_idx),
    .busy      (nv_busy),
    .nv_req    (nv_req),
    .nv_addr   (nv_addr),
    .nv_wdata  (nv_wdata)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Command words read zero when idle; the store word reads one during a store-command
  // save and the factory word reads one during a factory save, which the master polls on.
  logic [31:0] rd_mux;
  logic        store_busy_rd;
  logic        factory_busy_rd;

  assign store_busy_rd   = busy_any & ~factory_busy_r;
  assign factory_busy_rd = busy_any & factory_busy_r;

  // Unmapped words and the tuning and user default words read zero
  assign rd_mux = hit_store   ? {31'h0, store_busy_rd}   :
                  hit_factory ? {31'h0, factory_busy_rd} :
                  hit_div     ? div_stored_r             :
                  hit_mul     ? mul_stored_r             :
                  hit_rot     ? {31'h0, rot_stored_r}    : 32'h0000_0000;

  // Answer one cycle after the request; write wins if both strobes rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      ack_r <= par_wr | par_rd;
      err_r <= wr_refused | (par_rd & ~par_wr & ~hit_any);
      if (par_rd && !par_wr) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output below is a register
  assign par_rdata               = rdata_r;
  assign par_ack                 = ack_r;
  assign par_err                 = err_r;
  assign loop_gains_default      = gains_pulse_r;
  assign current_loop_autoset    = autoset_pulse_r;
  assign rotation_ccw            = rot_active_r;
  assign scale_multiplier_active = mul_active_r;
  assign scale_divisor_active    = div_active_r;

endmodule // dps_top

// ==== dps_pkg.sv ====
// Behaviour
// - Tuning reset value 1 restores speed and position loop gains to defaults.
// - Tuning reset also starts current loop setup for the attached motor.
// - Store command with bit 0 set copies user parameters to nonvolatile memory; the code also requires bits 31:16 to be zero.
// - Store command reads nonzero while storing, zero when done; master polls.
// - Factory command value 1 sets defaults then saves them to nonvolatile memory.
// - Factory defaults reach the running configuration only at next start-up.
// - Factory reset accepted from operator panel and from parameter port.
// - User defaults command 1 resets parameters except communication, control, logic type.
// - Rotation sense 0 is clockwise, 1 counterclockwise, clockwise by default.
// - Clockwise setting turns shaft clockwise for positive speed, seen at flange.
// - New rotation sense is stored but applies only after next power-on; reset reloads ROT_DEFAULT, so it never reaches rotation_ccw.
// - Divisor is signed 32-bit, range 1 to 2147483647, default 16384.
// - Scaling becomes active on multiplier write; divisor write alone is held.
// - Multiplier is signed 32-bit motor revolutions, range 1 to 2147483647.
package dps_pkg;

  // ----------------------------------------------------------------
  // Parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_TUNING_RESET = 16'h040e;
  localparam logic [15:0] ADDR_NV_STORE     = 16'h0402;
  localparam logic [15:0] ADDR_USER_DEFAULT = 16'h0410;
  localparam logic [15:0] ADDR_FACTORY      = 16'h0420;
  localparam logic [15:0] ADDR_SCALE_DIV    = 16'h060e;
  localparam logic [15:0] ADDR_SCALE_MUL    = 16'h0610;
  localparam logic [15:0] ADDR_ROTATION     = 16'h0618;

  // ----------------------------------------------------------------
  // Values, fields and defaults
  // ----------------------------------------------------------------
  localparam int          STORE_USER_BIT    = 0;
  localparam logic [31:0] CMD_EXECUTE       = 32'h0000_0001;
  localparam logic [31:0] FACTORY_MAX       = 32'h0000_0003;
  localparam logic [31:0] SCALE_MIN         = 32'h0000_0001;
  localparam logic [31:0] SCALE_MAX         = 32'h7fff_ffff;
  localparam logic [31:0] SCALE_DIV_DEFAULT = 32'h0000_4000;
  localparam logic [31:0] SCALE_MUL_DEFAULT = 32'h0000_0001;
  localparam logic        ROT_CLOCKWISE     = 1'b0;
  localparam logic        ROT_COUNTERCLOCK  = 1'b1;
  localparam logic        ROT_DEFAULT       = ROT_CLOCKWISE;

  // ----------------------------------------------------------------
  // Nonvolatile image layout
  // ----------------------------------------------------------------
  localparam int          NV_WORDS          = 3;
  localparam logic [1:0]  NV_IDX_ROTATION   = 2'h0;
  localparam logic [1:0]  NV_IDX_DIV        = 2'h1;
  localparam logic [1:0]  NV_IDX_MUL        = 2'h2;

  typedef enum logic [1:0] {
    DPS_NV_IDLE = 2'b00,
    DPS_NV_SEND = 2'b01,
    DPS_NV_WAIT = 2'b10
  } dps_nv_state_type;

endpackage : dps_pkg

// ==== dps_sync.sv ====
`timescale 1ns/1ps
module dps_sync
  import dps_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  // ----------------------------------------------------------------
  // Three-stage filter per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // First stage feeds only the second; accept when stages two and three agree
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[gi] = lvl_r;
    end
  endgenerate

endmodule // dps_sync

// ==== dps_nv_engine.sv ====
`timescale 1ns/1ps
module dps_nv_engine
  import dps_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] word_data,
  input  wire logic        nv_ack,
  output logic      [1:0]  word_idx,
  output logic             busy,
  output logic             nv_req,
  output logic      [1:0]  nv_addr,
  output logic      [31:0] nv_wdata
);

  dps_nv_state_type state_r;
  dps_nv_state_type state_nxt;
  logic [1:0]       idx_r;
  logic             last_word;

  // ----------------------------------------------------------------
  // Word sequencing
  // ----------------------------------------------------------------
  assign last_word = (idx_r == 2'(NV_WORDS - 1));
  assign word_idx  = idx_r;
  assign busy      = (state_r != DPS_NV_IDLE);

  // Next state; one word in flight at a time keeps the memory side simple
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DPS_NV_IDLE: if (start) state_nxt = DPS_NV_SEND;
      DPS_NV_SEND: state_nxt = DPS_NV_WAIT;
      DPS_NV_WAIT: begin
        if (nv_ack) begin
          state_nxt = last_word ? DPS_NV_IDLE : DPS_NV_SEND;
        end
      end
      default: state_nxt = DPS_NV_IDLE;
    endcase
  end

  // Request, address and data held until acknowledged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r  <= DPS_NV_IDLE;
      idx_r    <= 2'h0;
      nv_req   <= 1'b0;
      nv_addr  <= 2'h0;
      nv_wdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (state_r == DPS_NV_IDLE) begin
        idx_r <= 2'h0;
      end else if (state_r == DPS_NV_SEND) begin
        nv_req   <= 1'b1;
        nv_addr  <= idx_r;
        nv_wdata <= word_data;
      end else if (state_r == DPS_NV_WAIT && nv_ack) begin
        nv_req <= 1'b0;
        idx_r  <= idx_r + 2'h1;
      end
    end
  end

endmodule // dps_nv_engine

// ==== dps_properties.sv ====
`timescale 1ns/1ps
module dps_properties
  import dps_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  input wire logic [31:0] par_rdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic        nv_req,
  input wire logic [1:0]  nv_addr,
  input wire logic [31:0] nv_wdata,
  input wire logic        nv_ack,
  input wire logic        loop_gains_default,
  input wire logic        current_loop_autoset,
  input wire logic        rotation_ccw,
  input wire logic [31:0] scale_multiplier_active,
  input wire logic [31:0] scale_divisor_active
);
  // --------------------
  // Request decode
  // --------------------
  wire logic mapped = par_addr inside {ADDR_TUNING_RESET, ADDR_NV_STORE, ADDR_USER_DEFAULT,
    ADDR_FACTORY, ADDR_SCALE_DIV, ADDR_SCALE_MUL, ADDR_ROTATION};
  wire logic wr_mul = par_wr && par_addr == ADDR_SCALE_MUL;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // --------------------
  // Properties
  // --------------------
  property p_ack_follows;
    par_wr || par_rd |=> par_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");
  property p_unmapped;
    (par_wr || par_rd) && !mapped |=> par_err && par_ack;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_div_held;
    par_wr && par_addr == ADDR_SCALE_DIV |=> $stable(scale_divisor_active)
      && $stable(scale_multiplier_active);
  endproperty
  a_div_held: assert property (p_div_held) else $error("divisor applied alone");
  property p_mul_apply;
    wr_mul |=> par_err || scale_multiplier_active == $past(par_wdata);
  endproperty
  a_mul_apply: assert property (p_mul_apply) else $error("multiplier not applied");
  property p_mul_range;
    wr_mul && (par_wdata < SCALE_MIN || par_wdata > SCALE_MAX)
      |=> par_err && $stable(scale_multiplier_active);
  endproperty
  a_mul_range: assert property (p_mul_range) else $error("bad multiplier taken");
  property p_tuning_write;
    par_wr && par_addr == ADDR_TUNING_RESET && par_wdata == CMD_EXECUTE
      |=> par_err || (loop_gains_default && current_loop_autoset);
  endproperty
  a_tuning_write: assert property (p_tuning_write) else $error("tuning reset lost");
  property p_rot_hold;
    1'b1 |=> $stable(rotation_ccw);
  endproperty
  a_rot_hold: assert property (p_rot_hold) else $error("rotation changed live");
  property p_nv_hold;
    nv_req && !nv_ack |=> nv_req && $stable(nv_addr) && $stable(nv_wdata);
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("nv request dropped early");
  property p_store_start;
    par_wr && par_addr == ADDR_NV_STORE && par_wdata == CMD_EXECUTE
      |=> par_err or ##2 (nv_req && nv_addr == NV_IDX_ROTATION);
  endproperty
  a_store_start: assert property (p_store_start) else $error("store did not start");
endmodule // dps_properties

// ==== dps_nv_model.sv ====
`timescale 1ns/1ps
module dps_nv_model
  import dps_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        nv_req,
  input  wire logic [1:0]  nv_addr,
  input  wire logic [31:0] nv_wdata,
  input  wire logic [3:0]  lag,
  output logic             nv_ack
);
  logic [31:0] mem [NV_WORDS];
  logic [3:0]  wait_r;

  // Answer after lag cycles; a slow cell shows requests released too early
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nv_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (nv_ack) begin
      nv_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (nv_req && wait_r == lag) begin
      nv_ack <= 1'b1;
      mem[nv_addr] <= nv_wdata;
    end else if (nv_req) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // dps_nv_model

// ==== drive_param_store_scaling_bench.sv ====
`timescale 1ns/1ps
module drive_param_store_scaling_bench
  import dps_pkg::*;
;
  logic        clock, rst, par_wr, par_rd, pf, pt, nv_req, nv_ack, par_ack, par_err;
  logic        gains, autoset, rotation_ccw;
  logic [15:0] par_addr;
  logic [31:0] par_wdata, par_rdata, nv_wdata, mul_act, div_act, rd_v, err_v, gain_v;
  logic [1:0]  nv_addr;
  logic [3:0]  lag;
  int          failures, checks_done;

  dps_top dut (.clock(clock), .rst(rst), .par_wr(par_wr), .par_rd(par_rd),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_err(par_err), .panel_factory_code(pf), .panel_tuning_reset_code(pt),
    .nv_req(nv_req), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_ack(nv_ack),
    .loop_gains_default(gains), .current_loop_autoset(autoset), .rotation_ccw(rotation_ccw),
    .scale_multiplier_active(mul_act), .scale_divisor_active(div_act));
  dps_nv_model u_nv (.clock(clock), .rst(rst), .nv_req(nv_req), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .lag(lag), .nv_ack(nv_ack));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One access; answer is sampled once the ack edge has settled
  task automatic op(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    par_wr <= wr;
    par_rd <= !wr;
    par_addr <= a;
    par_wdata <= d;
    @(posedge clock);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    #1;
    chk(32'(par_ack), 32'h1);
    rd_v = par_rdata;
    err_v = 32'(par_err);
    gain_v = 32'(gains & autoset);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
    op(1'b1, a, d);
    chk(err_v, e);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    op(1'b0, a, 32'h0);
    chk(err_v, 32'h0);
    chk(rd_v, e);
  endtask
  // Poll a command word until it reads zero, bounded
  task automatic wait_idle(input logic [15:0] a);
    int n;
    n = 0;
    rd_v = 32'h1;
    while (rd_v !== 32'h0 && n < 60) begin
      op(1'b0, a, 32'h0);
      n++;
    end
    if (rd_v !== 32'h0) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic chk_nv(input logic [31:0] r, input logic [31:0] d, input logic [31:0] m);
    chk(u_nv.mem[0], r);
    chk(u_nv.mem[1], d);
    chk(u_nv.mem[2], m);
  endtask
  // Hold a panel pin past its filter and watch for the effect
  task automatic press(input logic fac);
    int n;
    logic hit;
    hit = 1'b0;
    @(posedge clock);
    if (fac) pf <= 1'b1;
    else pt <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      #1;
      hit = hit | (fac ? nv_req : (gains & autoset));
    end
    chk(32'(hit), 32'h1);
    @(posedge clock);
    pf <= 1'b0;
    pt <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    chk(div_act, SCALE_DIV_DEFAULT);
    chk(32'(rotation_ccw), 32'h0);
    rd(ADDR_ROTATION, 32'h0);
    rd(ADDR_SCALE_DIV, SCALE_DIV_DEFAULT);
    wr(16'h0500, 32'h1, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_scale();
    wr(ADDR_SCALE_DIV, 32'h7, 32'h0);
    chk(div_act, SCALE_DIV_DEFAULT);
    wr(ADDR_SCALE_DIV, 32'h0, 32'h1);
    wr(ADDR_SCALE_DIV, 32'h8000_0000, 32'h1);
    rd(ADDR_SCALE_DIV, 32'h7);
    wr(ADDR_SCALE_MUL, SCALE_MAX, 32'h0);
    chk(div_act, 32'h7);
    wr(ADDR_SCALE_MUL, 32'h0, 32'h1);
    chk(mul_act, SCALE_MAX);
    wr(ADDR_SCALE_MUL, 32'h5, 32'h0);
    wr(ADDR_ROTATION, 32'h1, 32'h0);
    chk(32'(rotation_ccw), 32'h0);
    rd(ADDR_ROTATION, 32'h1);
    wr(ADDR_ROTATION, 32'h2, 32'h1);
    $display("test scale done");
  endtask
  task automatic t_tuning();
    wr(ADDR_TUNING_RESET, CMD_EXECUTE, 32'h0);
    chk(gain_v, 32'h1);
    wr(ADDR_TUNING_RESET, 32'h0, 32'h0);
    chk(gain_v, 32'h0);
    wr(ADDR_TUNING_RESET, 32'h2, 32'h1);
    press(1'b0);
    $display("test tuning done");
  endtask
  task automatic t_store();
    lag <= 4'h5;
    wr(ADDR_NV_STORE, CMD_EXECUTE, 32'h0);
    rd(ADDR_NV_STORE, 32'h1);
    wr(ADDR_SCALE_DIV, 32'h9, 32'h1);
    wait_idle(ADDR_NV_STORE);
    chk_nv(32'h1, 32'h7, 32'h5);
    wr(ADDR_NV_STORE, 32'h0001_0001, 32'h1);
    wr(ADDR_NV_STORE, 32'h0, 32'h0);
    $display("test store done");
  endtask
  task automatic t_factory();
    lag <= 4'h0;
    wr(ADDR_FACTORY, CMD_EXECUTE, 32'h0);
    chk(div_act, 32'h7);
    chk(mul_act, 32'h5);
    wait_idle(ADDR_FACTORY);
    chk_nv({31'h0, ROT_DEFAULT}, SCALE_DIV_DEFAULT, SCALE_MUL_DEFAULT);
    rd(ADDR_SCALE_DIV, SCALE_DIV_DEFAULT);
    wr(ADDR_FACTORY, 32'h4, 32'h1);
    wr(ADDR_FACTORY, 32'h3, 32'h0);
    wr(ADDR_SCALE_DIV, 32'hb, 32'h0);
    press(1'b1);
    wait_idle(ADDR_FACTORY);
    chk(u_nv.mem[1], SCALE_DIV_DEFAULT);
    rd(ADDR_SCALE_DIV, SCALE_DIV_DEFAULT);
    $display("test factory done");
  endtask
  task automatic t_user();
    wr(ADDR_SCALE_DIV, 32'h9, 32'h0);
    wr(ADDR_SCALE_MUL, 32'h3, 32'h0);
    chk(div_act, 32'h9);
    wr(ADDR_USER_DEFAULT, CMD_EXECUTE, 32'h0);
    chk(mul_act, SCALE_MUL_DEFAULT);
    chk(div_act, SCALE_DIV_DEFAULT);
    rd(ADDR_USER_DEFAULT, 32'h0);
    wr(ADDR_USER_DEFAULT, 32'h2, 32'h1);
    $display("test user done");
  endtask

  // Clock source
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Main sequence
  initial begin
    {rst, par_wr, par_rd, pf, pt} = 5'h10;
    par_addr = 16'h0;
    par_wdata = 32'h0;
    lag = 4'h0;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_scale();
    t_tuning();
    t_store();
    t_factory();
    t_user();
    end_sim();
  end
endmodule // drive_param_store_scaling_bench

bind dps_top dps_properties u_props (.clock(clock), .rst(rst), .par_wr(par_wr),
  .par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
  .par_ack(par_ack), .par_err(par_err), .nv_req(nv_req), .nv_addr(nv_addr),
  .nv_wdata(nv_wdata), .nv_ack(nv_ack), .loop_gains_default(loop_gains_default),
  .current_loop_autoset(current_loop_autoset), .rotation_ccw(rotation_ccw),
  .scale_multiplier_active(scale_multiplier_active),
  .scale_divisor_active(scale_divisor_active));
